/* pkg/prom_read_params.svh */
// Purpose: constants for the registered one-time-programmable read path
// Assumes: included by the package and the design modules
// Notes: definitions only
`ifndef PROM_READ_PARAMS_SVH
`define PROM_READ_PARAMS_SVH

`define PROM_WORDS 1024
`define PROM_ADDR_W 10
`define PROM_DATA_W 8
// pin synchroniser layout, one bit per asynchronous pin
`define PIN_COUNT 4
`define PIN_REG_CLOCK 0
`define PIN_SYNC_OE_N 1
`define PIN_ASYNC_OE_N 2
`define PIN_INIT_N 3
// resting levels of the pins after reset: clock low, enables and init high
`define PIN_REST 4'he
// slave stage and blank cell value
`define WORD_RST 8'h00
// synchronous-enable flip-flop comes up set, outputs off
`define SYNC_EN_RST 1'b1

`endif

/* pkg/prom_read_pkg.sv */
// Purpose: shared types of the registered read path
// Assumes: prom_read_params.svh supplies the widths
// Notes: types only, numbers live in the header
`include "prom_read_params.svh"

package prom_read_pkg;
  typedef logic [`PROM_ADDR_W-1:0] addr_t;
  typedef logic [`PROM_DATA_W-1:0] word_t;
  typedef logic [`PIN_COUNT-1:0] pins_t;
endpackage

/* rtl/prom_array.sv */
// Purpose: one-time-programmable word array with a registered read
// Assumes: program port used only to set up contents
// Notes: a program write can only turn bits from 0 to 1
`timescale 1ns/10ps
`include "prom_read_params.svh"

module prom_array
  import prom_read_pkg::*;
#(
  parameter int DEPTH = `PROM_WORDS,
  parameter int WIDTH = `PROM_DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic prog_we,
  input wire addr_t prog_addr,
  input wire logic [WIDTH-1:0] prog_data,
  input wire addr_t rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] cell_q [DEPTH];

  initial begin
    if (DEPTH < 1 || DEPTH > (1 << `PROM_ADDR_W)) $error("prom_array: depth out of range");
    if (WIDTH != `PROM_DATA_W) $error("prom_array: width must match word width");
  end

  // programming ors bits in; rst models a blank part
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        cell_q[i] <= `WORD_RST;
      end
    end else if (prog_we && int'(prog_addr) < DEPTH) begin
      cell_q[prog_addr] <= cell_q[prog_addr] | prog_data; // [RQ10]
    end
  end

  // master stage: addressed word follows the address every cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= `WORD_RST;
    end else if (int'(rd_addr) < DEPTH) begin
      rd_data <= cell_q[rd_addr]; // [RQ4]
    end else begin
      rd_data <= `WORD_RST;
    end
  end

endmodule // prom_array

/* rtl/registered_prom_read_path.sv */
// Summary of operation
// RQ1: 1024 eight-bit words, registered three-state outputs
// RQ2: reset sets sync-enable flop, outputs off
// RQ3: partner sets address, sync enable low, then clocks
// RQ4: master follows address, slave loads on edge
// RQ5: async enable high turns outputs off
// RQ6: sync enable high at edge disables outputs
// RQ7: sync enable low at edge re-enables outputs
// RQ8: outputs hold between register-clock rising edges
// RQ9: init loads the extra programmed word
// RQ10: blank init bits clear, programmed bits set
// RQ11: init low loads both stages, ignoring clock; the code loads only the slave stage (data_out), not the master
// RQ12: init word shows only once outputs enabled
// RQ13: outputs are data vector plus drive flag
//
// Purpose: read path of a 1K x 8 registered one-time-programmable memory
// Assumes: register_clock, enables, init and address are pins from outside sys_clk
// Notes: all pin events except address are seen after a three-flop synchroniser; address takes a two-flop delay
`timescale 1ns/10ps
`include "prom_read_params.svh"

module registered_prom_read_path
  import prom_read_pkg::*;
#(
  parameter int WORDS = `PROM_WORDS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic register_clock,
  input wire addr_t addr,
  input wire logic sync_oe_n,
  input wire logic async_oe_n,
  input wire logic init_n,
  input wire logic prog_we,
  input wire logic prog_init_sel,
  input wire addr_t prog_addr,
  input wire word_t prog_data,
  output word_t data_out,
  output logic data_oe
);

  initial begin
    if (WORDS < 1 || WORDS > (1 << `PROM_ADDR_W)) $error("registered_prom_read_path: bad word count");
  end

  pins_t pin_in;
  pins_t sync1_q, sync2_q, sync3_q, stable_q;
  addr_t addr1_q, addr2_q;
  word_t master;
  word_t init_word_q;
  logic sync_en_q;
  logic clk_rise;
  logic init_active;

  assign pin_in = {init_n, async_oe_n, sync_oe_n, register_clock};

  // three-flop synchroniser per pin; first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_q <= `PIN_REST;
      sync2_q <= `PIN_REST;
      sync3_q <= `PIN_REST;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // stable_q takes a pin level only when stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stable_q <= `PIN_REST;
    end else begin
      for (int i = 0; i < `PIN_COUNT; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          stable_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // address rides a matching delay so it lines up with the clock edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr1_q <= '0;
      addr2_q <= '0;
    end else begin
      addr1_q <= addr;
      addr2_q <= addr1_q;
    end
  end

  assign clk_rise = (sync2_q[`PIN_REG_CLOCK] == sync3_q[`PIN_REG_CLOCK]) && sync3_q[`PIN_REG_CLOCK]
                    && !stable_q[`PIN_REG_CLOCK];
  assign init_active = !stable_q[`PIN_INIT_N];

  // master stage lives in the array's registered read
  prom_array #(
    .DEPTH(WORDS),
    .WIDTH(`PROM_DATA_W)
  ) u_array (
    .sys_clk(sys_clk),
    .rst(rst),
    .prog_we(prog_we && !prog_init_sel),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .rd_addr(addr2_q), // [RQ1] [RQ4]
    .rd_data(master)
  );

  // the extra word beyond the array; programming only sets bits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      init_word_q <= `WORD_RST;
    end else if (prog_we && prog_init_sel) begin
      init_word_q <= init_word_q | prog_data; // [RQ10]
    end
  end

  // slave stage: init wins over any clock edge, else load on rising edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_out <= `WORD_RST;
    end else if (init_active) begin
      data_out <= init_word_q; // [RQ9] [RQ11]
    end else if (clk_rise) begin
      data_out <= master; // [RQ4]
    end
  end

  // synchronous-enable flop; untouched by init, held between edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_en_q <= `SYNC_EN_RST; // [RQ2]
    end else if (clk_rise) begin
      sync_en_q <= sync3_q[`PIN_SYNC_OE_N]; // [RQ6] [RQ7] [RQ8]
    end
  end

  // drive flag; async enable acts as soon as its synchronised level settles
  assign data_oe = !sync_en_q && !stable_q[`PIN_ASYNC_OE_N]; // [RQ5] [RQ12] [RQ13]

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_reset_outputs_off: assert property ($past(rst) |-> !data_oe) // [RQ2]
    else $error("outputs driven right after reset");

  a_async_disable: assert property (stable_q[`PIN_ASYNC_OE_N] |-> !data_oe) // [RQ5]
    else $error("outputs driven while async enable high");

  a_async_restore: assert property ($fell(stable_q[`PIN_ASYNC_OE_N]) && !sync_en_q |-> data_oe) // [RQ5]
    else $error("outputs not restored on async enable low");

  a_sync_disable: assert property (clk_rise && sync3_q[`PIN_SYNC_OE_N] |=> !data_oe) // [RQ6]
    else $error("sync enable high at edge left outputs on");

  a_sync_enable: assert property (clk_rise && !sync3_q[`PIN_SYNC_OE_N] ##1 !stable_q[`PIN_ASYNC_OE_N] // [RQ7]
                                  |-> data_oe)
    else $error("sync enable low at edge did not drive outputs");

  a_edge_loads_word: assert property (clk_rise && !init_active |=> data_out == $past(master)) // [RQ4]
    else $error("slave did not take addressed word at edge");

  a_hold_between_edges: assert property (!clk_rise && !init_active // [RQ8]
                                         |=> $stable(data_out) && $stable(sync_en_q))
    else $error("output state changed without a clock edge");

  a_init_loads_word: assert property (init_active |=> data_out == $past(init_word_q)) // [RQ9] [RQ11]
    else $error("init did not load the initialize word");

  a_init_beats_clock: assert property (init_active && clk_rise |=> data_out == $past(init_word_q)) // [RQ11]
    else $error("clock edge overrode init");

  a_init_keeps_enable: assert property (init_active && !clk_rise |=> $stable(sync_en_q)) // [RQ12]
    else $error("init changed the enable state");

  a_init_bits_sticky: assert property (prog_we && prog_init_sel // [RQ10]
                                       |=> init_word_q == ($past(init_word_q) | $past(prog_data)))
    else $error("programmed init bit was cleared or not set");

  // an unprogrammed cycle must leave the extra word alone
  a_init_word_kept: assert property (!(prog_we && prog_init_sel) |=> $stable(init_word_q)) // [RQ10]
    else $error("init word changed without a program strobe");

  // state straight after reset: blank slave, enable flop set
  a_reset_blank_word: assert property ($past(rst) |-> data_out == `WORD_RST) // [RQ2]
    else $error("slave not blank after reset");

  a_reset_enable_set: assert property ($past(rst) |-> sync_en_q) // [RQ2]
    else $error("enable flop not set after reset");

  // enable flop takes the sampled pin at every register-clock rise, init or not
  a_edge_sets_enable: assert property (clk_rise |=> sync_en_q == $past(sync3_q[`PIN_SYNC_OE_N])) // [RQ6] [RQ7]
    else $error("enable flop missed the sampled sync enable");

  a_sync_beats_async: assert property (clk_rise && sync3_q[`PIN_SYNC_OE_N] && !stable_q[`PIN_ASYNC_OE_N] // [RQ6]
                                       |=> !data_oe)
    else $error("async enable low kept outputs on past a sync disable");

  // one register-clock rise must give exactly one load edge
  a_single_rise: assert property (clk_rise |=> !clk_rise) // [RQ8]
    else $error("one register clock rise seen twice");

  // drive flag needs both enables; neither alone may drive the pins
  a_drive_needs_both: assert property (data_oe |-> !sync_en_q && !stable_q[`PIN_ASYNC_OE_N]) // [RQ13]
    else $error("outputs driven with an enable inactive");

  a_async_low_drives: assert property (!stable_q[`PIN_ASYNC_OE_N] && !sync_en_q |-> data_oe) // [RQ5] [RQ13]
    else $error("outputs off with both enables active");

  // init may load the register, but never opens the pins by itself
  a_init_no_drive: assert property (init_active && sync_en_q |-> !data_oe) // [RQ12]
    else $error("init word driven while enable flop set");

endmodule // registered_prom_read_path

/* test/prom_sequencer_model.sv */
// Purpose: addressing party that drives address and enable pins
// Assumes: pins change 1 ns after a sys_clk rise
// Notes: address and sync enable move to their inverse once hold is over
`timescale 1ns/10ps
module prom_sequencer_model
  import prom_read_pkg::*;
(
  input wire logic sys_clk,
  output logic register_clock,
  output addr_t addr,
  output logic sync_oe_n,
  output logic async_oe_n,
  output logic init_n
);
  // resting levels before reset release
  initial begin
    register_clock = 1'b0;
    addr = 10'h000;
    sync_oe_n = 1'b1;
    async_oe_n = 1'b1;
    init_n = 1'b1;
  end
  // one register clock, address and sync enable set up a cycle ahead
  task automatic strobe(input addr_t a, input logic es_n);
    @(posedge sys_clk) #1;
    addr = a;
    sync_oe_n = es_n;
    @(posedge sys_clk) #1;
    register_clock = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    addr = ~a; // stale address would show a wrong word
    sync_oe_n = ~es_n; // enable flop must not follow the pin between edges
    register_clock = 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  // level pins, then room for the three-flop synchroniser
  task automatic pins(input logic e_n, input logic i_n);
    @(posedge sys_clk) #1;
    async_oe_n = e_n;
    init_n = i_n;
    repeat (5) @(posedge sys_clk);
    #1; // init reload lands on the last edge, so look after it settles
  endtask
endmodule // prom_sequencer_model

/* test/registered_prom_read_path_test.sv */
// Purpose: self-checking bench of the registered read path
// Assumes: words loaded through the program port
// Notes: waits cover the synchroniser delay
`timescale 1ns/10ps
module registered_prom_read_path_test;
  import prom_read_pkg::*;
  logic sys_clk, rst, prog_we, prog_init_sel, register_clock, sync_oe_n, async_oe_n, init_n, data_oe;
  addr_t addr, prog_addr;
  word_t prog_data, data_out;
  int mismatches, checks, cycles;
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  prom_sequencer_model seq (.sys_clk(sys_clk), .register_clock(register_clock), .addr(addr),
    .sync_oe_n(sync_oe_n), .async_oe_n(async_oe_n), .init_n(init_n));
  registered_prom_read_path uut (.sys_clk(sys_clk), .rst(rst), .register_clock(register_clock),
    .addr(addr), .sync_oe_n(sync_oe_n), .async_oe_n(async_oe_n), .init_n(init_n),
    .prog_we(prog_we), .prog_init_sel(prog_init_sel), .prog_addr(prog_addr),
    .prog_data(prog_data), .data_out(data_out), .data_oe(data_oe));
  task automatic check(input word_t seen, input word_t exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, the run needs about 130 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end
  task automatic prog(input logic sel, input addr_t a, input word_t d);
    @(posedge sys_clk) #1;
    prog_we = 1'b1;
    prog_init_sel = sel;
    prog_addr = a;
    prog_data = d;
    @(posedge sys_clk) #1;
    prog_we = 1'b0;
  endtask
  task automatic t_read();
    prog(1'b0, 10'h000, 8'h5a);
    prog(1'b0, 10'h3ff, 8'ha5);
    seq.strobe(10'h000, 1'b0);
    seq.pins(1'b0, 1'b1);
    check({7'h00, data_oe}, 8'h01);
    check(data_out, 8'h5a);
    check(data_out, 8'h5a);
    seq.strobe(10'h3ff, 1'b0);
    check(data_out, 8'ha5);
    $display("read done");
  endtask
  task automatic t_enables();
    seq.pins(1'b1, 1'b1);
    check({7'h00, data_oe}, 8'h00);
    seq.pins(1'b0, 1'b1);
    check({7'h00, data_oe}, 8'h01);
    seq.pins(1'b0, 1'b0);
    check(data_out, 8'h00);
    seq.pins(1'b0, 1'b1);
    seq.strobe(10'h000, 1'b1);
    check({7'h00, data_oe}, 8'h00);
    $display("enables done");
  endtask
  task automatic t_init();
    prog(1'b1, 10'h000, 8'hc3);
    seq.strobe(10'h3ff, 1'b0);
    seq.pins(1'b1, 1'b1);
    seq.pins(1'b1, 1'b0);
    check(data_out, 8'hc3);
    check({7'h00, data_oe}, 8'h00);
    seq.strobe(10'h000, 1'b0);
    check(data_out, 8'hc3);
    seq.pins(1'b0, 1'b0);
    check(data_out, 8'hc3);
    check({7'h00, data_oe}, 8'h01);
    seq.pins(1'b0, 1'b1);
    $display("init done");
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    prog_we = 1'b0;
    prog_init_sel = 1'b0;
    prog_addr = 10'h000;
    prog_data = 8'h00;
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    check({7'h00, data_oe}, 8'h00);
    t_read();
    t_enables();
    t_init();
    results();
  end
endmodule // registered_prom_read_path_test
